/* rcc_pkg.sv */
// Package of register map, field positions and reset values for the ROM cache control block
package rcc_pkg;

    // ------------------------------------------------------------
    // Register byte addresses
    // ------------------------------------------------------------
    localparam logic [31:0] RCC_CTRL_ADDR = 32'hFFFC1400; // First control register
    localparam logic [31:0] RCC_CTRL_TWO_ADDR = 32'hFFFC1408; // Second control register

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] RCC_CTRL_RESET = 32'h00000001;
    localparam logic [31:0] RCC_CTRL_TWO_RESET = 32'h000000F5;

    // ------------------------------------------------------------
    // Field positions, first control register
    // ------------------------------------------------------------
    localparam int RCC_GLOBAL_EN_BIT = 0;
    localparam int RCC_FLUSH_DATA_BIT = 1;
    localparam int RCC_FLUSH_INSTR_BIT = 2;
    localparam int RCC_FLUSH_ALL_BIT = 3;

    // ------------------------------------------------------------
    // Field positions, second control register
    // ------------------------------------------------------------
    localparam int RCC_DATA_EN_BIT = 0;
    localparam int RCC_MISS_EN_BIT = 2;
    localparam int RCC_PREF_EN_BIT = 4;
    localparam int RCC_SEQ_EN_BIT = 5;
    localparam int RCC_UNCOND_EN_BIT = 6;
    localparam int RCC_COND_EN_BIT = 7;

    // Writable bits of the second register; everything else reads zero
    localparam logic [7:0] RCC_CTRL_TWO_MASK = 8'hF5;

    // ------------------------------------------------------------
    // Bus encodings
    // ------------------------------------------------------------
    localparam logic [1:0] RCC_HTRANS_NONSEQ = 2'h2;
    localparam logic [1:0] RCC_HTRANS_SEQ = 2'h3;
    localparam logic [2:0] RCC_HSIZE_WORD = 3'h2;

endpackage : rcc_pkg

/* rcc_flush_pulse.sv */
// Flush pulse encoder turning written flush bits into per-cache invalidate strobes
`timescale 1ns/1ps

module rcc_flush_pulse
    import rcc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Accepted write of the first control register
    input wire logic wr_en,
    input wire logic [3:0] wr_bits,
    // Registered invalidate strobes
    output logic flush_data,
    output logic flush_instr
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic data;  // Data cache strobe
        logic instr; // Both instruction caches strobe
    } rcc_flush_type;

    rcc_flush_type state_reg;
    rcc_flush_type state_next;

    // Union of selected caches taken in the one write
    always_comb begin
        state_next = '0;
        if (wr_en) begin
            state_next.data = wr_bits[RCC_FLUSH_ALL_BIT] | wr_bits[RCC_FLUSH_DATA_BIT];
            state_next.instr = wr_bits[RCC_FLUSH_ALL_BIT] | wr_bits[RCC_FLUSH_INSTR_BIT];
        end
    end

    // One-cycle strobes, idle after reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= '0;
        end else begin
            state_reg <= state_next;
        end
    end

    assign flush_data = state_reg.data;
    assign flush_instr = state_reg.instr;

endmodule : rcc_flush_pulse

/* rcc_regs.sv */
// AHB-Lite register block controlling the ROM cache enables, prefetch policy and flushes
//
// Functional notes
// - Registers accept only 32-bit word accesses
// - Global flush invalidates all three caches
// - Instruction flush invalidates prefetch and miss caches
// - Data flush invalidates only data cache
// - Flush bits always read back zero
// - Global enable, resets to one
// - Miss and data cache enables, reset one
// - Prefetch cache enable, resets to one
// - Conditional branch prefetch enable, resets one
// - Unconditional branch prefetch enable, resets one
// - Sequential prefetch enable, resets to one
// - Reserved bits read zero, writes ignored
// - Line valid only while flag set
// - Data lookup needs global and data enables
`timescale 1ns/1ps

module rcc_regs
    import rcc_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // Standby entry, restores defaults like reset
    input wire logic standby,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic [31:0] hrdata,
    output logic hreadyout,
    output logic hresp,
    // Cache enable controls
    output logic global_cache_enable,
    output logic data_cache_enable,
    output logic miss_cache_enable,
    output logic prefetch_cache_enable,
    // Prefetch policy controls
    output logic cond_branch_prefetch_enable,
    output logic uncond_branch_prefetch_enable,
    output logic sequential_prefetch_enable,
    // Qualified lookup enables
    output logic data_lookup_enable,
    output logic instr_lookup_enable,
    // Valid flag clear strobes, one cycle each
    output logic data_valid_clear,
    output logic prefetch_valid_clear,
    output logic miss_valid_clear
);

    // ------------------------------------------------------------
    // Address decode helper
    // ------------------------------------------------------------

    // Register select: 0 none, 1 first, 2 second
    function automatic logic [1:0] reg_sel(input logic [31:0] addr);
        if (addr == RCC_CTRL_ADDR) begin
            reg_sel = 2'h1;
        end else if (addr == RCC_CTRL_TWO_ADDR) begin
            reg_sel = 2'h2;
        end else begin
            reg_sel = 2'h0;
        end
    endfunction : reg_sel

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef struct packed {
        logic global_en;   // Global cache enable
        logic [7:0] two;   // Second register contents
        logic wr_pend;     // Write data phase pending
        logic [1:0] wr_sel; // Register latched in the address phase
        logic [31:0] rdata; // Read data for the data phase
        logic data_look;   // Registered data lookup enable
        logic instr_look;  // Registered instruction lookup enable
    } rcc_state_type;

    rcc_state_type state_reg;
    rcc_state_type state_next;

    // Reset image of the whole state
    localparam rcc_state_type RCC_STATE_RESET = '{
        global_en: RCC_CTRL_RESET[RCC_GLOBAL_EN_BIT],
        two: RCC_CTRL_TWO_RESET[7:0],
        wr_pend: 1'b0,
        wr_sel: 2'h0,
        rdata: 32'h00000000,
        data_look: 1'b1,
        instr_look: 1'b1
    };

    // Address phase qualifier; SEQ counted too although masters here issue NONSEQ only
    logic addr_valid;
    // Accepted word write to the first register, for the flush encoder
    logic ctrl_wr;
    // Flush strobes from the encoder
    logic flush_data;
    logic flush_instr;

    assign addr_valid = hsel && hready && (htrans == RCC_HTRANS_NONSEQ || htrans == RCC_HTRANS_SEQ);
    assign ctrl_wr = state_reg.wr_pend && state_reg.wr_sel == 2'h1;

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------

    // Bus decode, register writes and read data
    always_comb begin
        state_next = state_reg;
        state_next.wr_pend = 1'b0;
        // Data phase of a write: commit into the selected register
        if (state_reg.wr_pend) begin
            unique case (state_reg.wr_sel)
                2'h1: begin
                    state_next.global_en = hwdata[RCC_GLOBAL_EN_BIT];
                end
                2'h2: begin
                    state_next.two = hwdata[7:0] & RCC_CTRL_TWO_MASK;
                end
                default: begin
                    // Unmapped address: write dropped
                end
            endcase
        end
        // Address phase: only whole words are honoured
        if (addr_valid) begin
            if (hsize == RCC_HSIZE_WORD) begin
                state_next.wr_pend = hwrite;
                state_next.wr_sel = reg_sel(haddr);
                // Read data prepared now so it stands in the data phase
                if (!hwrite) begin
                    unique case (reg_sel(haddr))
                        2'h1: begin
                            // Flush bits read as zero, reserved bits too
                            state_next.rdata = {31'h00000000, state_reg.global_en};
                        end
                        2'h2: begin
                            state_next.rdata = {24'h000000, state_reg.two};
                        end
                        default: begin
                            state_next.rdata = 32'h00000000;
                        end
                    endcase
                end else begin
                    state_next.rdata = 32'h00000000;
                end
            end else begin
                // Narrow access: ignored, reads zero
                state_next.wr_pend = 1'b0;
                state_next.wr_sel = 2'h0;
                state_next.rdata = 32'h00000000;
            end
        end
        // Lookup gating follows the enables as they will stand next cycle
        state_next.data_look = state_next.global_en & state_next.two[RCC_DATA_EN_BIT];
        state_next.instr_look = state_next.global_en
            & (state_next.two[RCC_PREF_EN_BIT] | state_next.two[RCC_MISS_EN_BIT]);
        // Standby restores defaults; bus is idle in standby
        if (standby) begin
            state_next = RCC_STATE_RESET;
        end
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------

    // Single state register, defaults under reset
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            state_reg <= RCC_STATE_RESET;
        end else begin
            state_reg <= state_next;
        end
    end

    // Flush encoder, strobes one cycle after the data phase
    rcc_flush_pulse u_flush (
        .hclk(hclk),
        .hresetn(hresetn),
        .wr_en(ctrl_wr),
        .wr_bits(hwdata[3:0]),
        .flush_data(flush_data),
        .flush_instr(flush_instr)
    );

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------

    // Zero wait states, always OKAY
    assign hreadyout = 1'b1;
    assign hresp = 1'b0;
    assign hrdata = state_reg.rdata;

    // Enables straight from the register bits
    assign global_cache_enable = state_reg.global_en;
    assign data_cache_enable = state_reg.two[RCC_DATA_EN_BIT];
    assign miss_cache_enable = state_reg.two[RCC_MISS_EN_BIT];
    assign prefetch_cache_enable = state_reg.two[RCC_PREF_EN_BIT];
    assign cond_branch_prefetch_enable = state_reg.two[RCC_COND_EN_BIT];
    assign uncond_branch_prefetch_enable = state_reg.two[RCC_UNCOND_EN_BIT];
    assign sequential_prefetch_enable = state_reg.two[RCC_SEQ_EN_BIT];
    assign data_lookup_enable = state_reg.data_look;
    assign instr_lookup_enable = state_reg.instr_look;

    // Strobes drive the valid flags of the arrays to zero
    assign data_valid_clear = flush_data;
    assign prefetch_valid_clear = flush_instr;
    assign miss_valid_clear = flush_instr;

endmodule : rcc_regs

/* rcc_regs_assertions.sv */
// Concurrent checks on the ROM cache control register ports
`timescale 1ns/1ps
module rcc_regs_chk
    import rcc_pkg::*;
(
    // Clock, reset, standby
    input wire logic hclk,
    input wire logic hresetn,
    input wire logic standby,
    // Bus side
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    input wire logic [31:0] hrdata,
    input wire logic hreadyout,
    input wire logic hresp,
    // Controls
    input wire logic global_cache_enable,
    input wire logic data_cache_enable,
    input wire logic data_lookup_enable,
    input wire logic data_valid_clear,
    input wire logic prefetch_valid_clear,
    input wire logic miss_valid_clear
);
    logic hit; // Word address phase to the first register
    logic wr_q; // Its write data phase
    logic rd_q; // Its read data phase
    assign hit = hsel && hready && htrans[1] && hsize == RCC_HSIZE_WORD && haddr == RCC_CTRL_ADDR;
    // Phase markers, cleared by reset so no stale phase survives it
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
        end else begin
            wr_q <= hit && hwrite && !standby;
            rd_q <= hit && !hwrite && !standby;
        end
    end
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);
    a_bus_okay: assert property (hreadyout && !hresp)
        else $error("bus answer not ready or not OKAY");
    a_data_lookup: assert property (
        data_lookup_enable == (global_cache_enable && data_cache_enable))
        else $error("data lookup gate wrong");
    a_clear_pair: assert property (prefetch_valid_clear == miss_valid_clear)
        else $error("instruction clears differ");
    a_flush_data: assert property (wr_q && (hwdata[1] || hwdata[3]) |-> ##1 data_valid_clear)
        else $error("data clear missing");
    a_flush_instr: assert property (
        wr_q && (hwdata[2] || hwdata[3]) |-> ##1 prefetch_valid_clear)
        else $error("instruction clear missing");
    a_data_spared: assert property (wr_q && !hwdata[1] && !hwdata[3] |-> ##1 !data_valid_clear)
        else $error("data cache cleared wrongly");
    a_instr_spared: assert property (
        wr_q && !hwdata[2] && !hwdata[3] |-> ##1 !prefetch_valid_clear)
        else $error("instruction caches cleared wrongly");
    a_enable_write: assert property (wr_q |=> global_cache_enable == $past(hwdata[0]))
        else $error("global enable not written");
    a_flush_zero: assert property (rd_q |-> hrdata[31:1] == 31'h0)
        else $error("flush or reserved bits read nonzero");
    a_standby_on: assert property (standby |=> global_cache_enable && data_cache_enable)
        else $error("standby left enables off");
    c_flush: cover property (wr_q && hwdata[3]);
    c_read: cover property (rd_q);
    c_standby: cover property (standby);
endmodule : rcc_regs_chk

bind rcc_regs rcc_regs_chk u_chk (.hclk(hclk), .hresetn(hresetn), .standby(standby),
    .hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize),
    .hwdata(hwdata), .hready(hready), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
    .global_cache_enable(global_cache_enable), .data_cache_enable(data_cache_enable),
    .data_lookup_enable(data_lookup_enable), .data_valid_clear(data_valid_clear),
    .prefetch_valid_clear(prefetch_valid_clear), .miss_valid_clear(miss_valid_clear));

/* rcc_regs_tb.sv */
// Self-checking bench for the ROM cache control registers
`timescale 1ns/1ps
module rcc_regs_tb
    import rcc_pkg::*;
;
    logic hclk = 1'b0;
    logic hresetn = 1'b0;
    logic standby = 1'b0;
    logic hsel = 1'b0;
    logic hwrite = 1'b0;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic [31:0] haddr = 32'h0;
    logic [31:0] hwdata = 32'h0;
    logic [31:0] hrdata, rd;
    logic hreadyout, hresp, global_cache_enable, data_cache_enable, miss_cache_enable;
    logic prefetch_cache_enable, cond_branch_prefetch_enable, uncond_branch_prefetch_enable;
    logic sequential_prefetch_enable, data_lookup_enable, instr_lookup_enable;
    logic data_valid_clear, prefetch_valid_clear, miss_valid_clear;
    logic [7:0] enab; // Enables laid out as in the second register
    int n_mismatch = 0;
    int num_checks = 0;
    assign enab = {cond_branch_prefetch_enable, uncond_branch_prefetch_enable,
        sequential_prefetch_enable, prefetch_cache_enable, 1'b0, miss_cache_enable, 1'b0,
        data_cache_enable};
    always #4 hclk = ~hclk;
    // Single slave, so its ready is the bus ready
    rcc_regs DUT (.hclk(hclk), .hresetn(hresetn), .standby(standby), .hsel(hsel),
        .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
        .hready(hreadyout), .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp),
        .global_cache_enable(global_cache_enable), .data_cache_enable(data_cache_enable),
        .miss_cache_enable(miss_cache_enable), .prefetch_cache_enable(prefetch_cache_enable),
        .cond_branch_prefetch_enable(cond_branch_prefetch_enable),
        .uncond_branch_prefetch_enable(uncond_branch_prefetch_enable),
        .sequential_prefetch_enable(sequential_prefetch_enable),
        .data_lookup_enable(data_lookup_enable), .instr_lookup_enable(instr_lookup_enable),
        .data_valid_clear(data_valid_clear), .prefetch_valid_clear(prefetch_valid_clear),
        .miss_valid_clear(miss_valid_clear));
    task automatic tally_and_finish();
        $display("checks %0d mismatches %0d", num_checks, n_mismatch);
        if (n_mismatch == 0 && num_checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : tally_and_finish
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        num_checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask : chk
    // Bounded wait for ready at a rising edge
    task automatic wait_rdy();
        int n = 0;
        @(posedge hclk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 20) begin
                n_mismatch++;
                tally_and_finish();
            end
            @(posedge hclk);
        end
    endtask : wait_rdy
    // One AHB-Lite single transfer; read data lands in rd
    task automatic bus(input logic wr, input logic [31:0] a, input logic [2:0] sz,
        input logic [31:0] wd);
        @(posedge hclk);
        hsel <= 1'b1;
        htrans <= RCC_HTRANS_NONSEQ;
        haddr <= a;
        hwrite <= wr;
        hsize <= sz;
        wait_rdy();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wd;
        wait_rdy();
        rd = hrdata;
    endtask : bus
    task automatic rdc(input logic [31:0] a, input logic [31:0] exp);
        bus(1'b0, a, RCC_HSIZE_WORD, 32'h0);
        chk(rd, exp);
    endtask : rdc
    initial begin
        repeat (4) @(posedge hclk);
        hresetn <= 1'b1;
        chk({24'h0, enab}, RCC_CTRL_TWO_RESET);
        rdc(RCC_CTRL_ADDR, RCC_CTRL_RESET);
        rdc(RCC_CTRL_TWO_ADDR, RCC_CTRL_TWO_RESET);
        $display("test reset values done");
        for (int b = 0; b < 32; b++) begin
            bus(1'b1, RCC_CTRL_TWO_ADDR, RCC_HSIZE_WORD, 32'h1 << b);
            rdc(RCC_CTRL_TWO_ADDR, (32'h1 << b) & 32'h000000F5);
            chk({24'h0, enab}, (32'h1 << b) & 32'h000000F5);
            chk({31'h0, data_lookup_enable}, 32'(b == 0));
        end
        bus(1'b1, RCC_CTRL_TWO_ADDR, RCC_HSIZE_WORD, 32'hFFFFFFFF);
        bus(1'b1, RCC_CTRL_TWO_ADDR, 3'h0, 32'h0);
        rdc(RCC_CTRL_TWO_ADDR, 32'h000000F5);
        rdc(32'hFFFC1404, 32'h0);
        $display("test second register done");
        for (int v = 1; v < 8; v++) begin
            bus(1'b1, RCC_CTRL_ADDR, RCC_HSIZE_WORD, 32'((v << 1) | 1));
            #1;
            chk({29'h0, data_valid_clear, prefetch_valid_clear, miss_valid_clear},
                32'((v[0] | v[2]) * 4 + (v[1] | v[2]) * 3));
            rdc(RCC_CTRL_ADDR, 32'h1);
        end
        bus(1'b1, RCC_CTRL_ADDR, RCC_HSIZE_WORD, 32'hFFFFFFF0);
        rdc(RCC_CTRL_ADDR, 32'h0);
        chk({30'h0, data_lookup_enable, instr_lookup_enable}, 32'h0);
        $display("test flush and enable done");
        bus(1'b1, RCC_CTRL_TWO_ADDR, RCC_HSIZE_WORD, 32'h0);
        @(posedge hclk);
        standby <= 1'b1;
        @(posedge hclk);
        standby <= 1'b0;
        #1;
        chk({23'h0, global_cache_enable, enab}, 32'h000001F5);
        rdc(RCC_CTRL_ADDR, RCC_CTRL_RESET);
        $display("test standby done");
        tally_and_finish();
    end
endmodule : rcc_regs_tb
